// ===== verilog/vbedc_map.vh
// Offsets, fields, resets, codes and timing for the VPW error and delay control
`ifndef VBEDC_MAP_VH
`define VBEDC_MAP_VH

// ----------------------------------------
// Register indices on the CPU port
// ----------------------------------------
`define VBEDC_IDX_DELAY 2'h0
`define VBEDC_IDX_CTRL1 2'h1
`define VBEDC_IDX_SVR   2'h2

// ----------------------------------------
// Reset values and field positions
// ----------------------------------------
`define VBEDC_DELAY_RST 8'h47
`define VBEDC_CTRL1_RST 8'h00
`define VBEDC_BIT_ATE   7
`define VBEDC_BIT_RECEIVE_POLARITY 6
`define VBEDC_BIT_IGNORE_MESSAGE  7
`define VBEDC_BIT_IE    1
`define VBEDC_BIT_LOA   7

// ----------------------------------------
// State vector codes, highest priority first
// ----------------------------------------
`define VBEDC_SV_INV  6'h1C
`define VBEDC_SV_CRC  6'h18
`define VBEDC_SV_TXE  6'h20
`define VBEDC_SV_NONE 6'h00

// ----------------------------------------
// Decoded symbol codes
// ----------------------------------------
`define VBEDC_SYM_D0  3'h0
`define VBEDC_SYM_D1  3'h1
`define VBEDC_SYM_SOF 3'h2
`define VBEDC_SYM_EOD 3'h3
`define VBEDC_SYM_EOF 3'h4
`define VBEDC_SYM_BRK 3'h5
`define VBEDC_SYM_INV 3'h6

// ----------------------------------------
// Timing
// ----------------------------------------
`define VBEDC_CLK_MHZ     50
`define VBEDC_DLY_BASE_US 9
`define VBEDC_SHORT_US    500
`define VBEDC_LOA_US      2000
`define VBEDC_SHORT_CYC   (`VBEDC_SHORT_US * `VBEDC_CLK_MHZ)
`define VBEDC_LOA_CYC     (`VBEDC_LOA_US * `VBEDC_CLK_MHZ)

`endif

// ===== verilog/vbedc_error_ctl.v
// VPW link error detection, recovery, delay compensation and ignore control
// Operation
// - Invalid received symbol sets invalid-symbol status
// - EOD/EOF off byte boundary is framing error
// - Active symbol during own EOD is framing
// - Defer transmit while bus held dominant
// - Undriveable SOF: error, abort, await CPU
// - Resume normally once fault clears
// - BREAK raises invalid-symbol; vector read clears
// - After BREAK, await idle then SOF
// - Never drive a BREAK symbol
// - CRC mismatch: CRC condition, await EOF
// - Noise while sending: abort, invalid-symbol
// - Framing error: invalid-symbol, await EOF
// - Supply short: invalid, await EOF, maybe arbitration-loss
// - Own frame error: invalid-symbol, stop sending
// - Ground short: invalid flag, await EOF
// - Delay default 16us, range 9 to 24
// - Delay register writable once, always readable
// - Delay equals 9us plus offset field
// - Transceiver select: 1 on-board, 0 off-chip; the bit only drives txSelect, no on-board path here
// - Receive polarity: 1 true, 0 inverted
// - Ignore bit: drop frame, mask, hold status
// - Ignore bit self-clears on SOF or BREAK
// - Interrupt enable gates persistent requests
`include "vbedc_map.vh"

module vbedc_error_ctl #(
    parameter [19:0] SHORT_CYC = `VBEDC_SHORT_CYC,
    parameter [19:0] LOA_CYC   = `VBEDC_LOA_CYC
)(
    input  wire        clk,
    input  wire        sys_rst,
    input  wire [1:0]  regSel,
    input  wire        regWr,
    input  wire        regRd,
    input  wire [7:0]  regWrData,
    output reg  [7:0]  regRdData,
    input  wire        rxPin,
    input  wire        symStb,
    input  wire [2:0]  symCode,
    input  wire        busIdle,
    input  wire        eodPhase,
    input  wire        crcBad,
    input  wire        txReq,
    input  wire        txBufEmpty,
    input  wire        sofWindowEnd,
    input  wire        txDone,
    output wire        rxData,
    output wire        txStart,
    output wire        txDrive,
    output wire        txAbort,
    output wire        rxSuspend,
    output wire        irq,
    output reg  [10:0] delayCyc,
    output wire        txSelect,
    output wire        lostArb
);

    // ----------------------------------------
    // Constants and helpers
    // ----------------------------------------
    localparam [1:0] TX_IDLE  = 2'h0;
    localparam [1:0] TX_DEFER = 2'h1;
    localparam [1:0] TX_SOF   = 2'h2;
    localparam [1:0] TX_SEND  = 2'h3;
    localparam [7:0] DELAY_RST = `VBEDC_DELAY_RST;

    // Strobed symbol match
    function symHit;
        input       stb;
        input [2:0] code;
        input [2:0] want;
        begin
            symHit = stb & (code == want);
        end
    endfunction

    // Offset code to delay in clock cycles
    function [10:0] dlyCyc;
        input [3:0] bo;
        reg   [10:0] us;
        begin
            us = 11'd`VBEDC_DLY_BASE_US + {7'h00, bo};
            dlyCyc = us * 11'd`VBEDC_CLK_MHZ;
        end
    endfunction

    // ----------------------------------------
    // State
    // ----------------------------------------
    reg  [7:0]  delay_q;
    reg         delayLock_q;
    reg  [7:0]  ctrl1_q;
    reg  [1:0]  tx_q;
    reg  [1:0]  tx_d;
    reg         reqPend_q;
    reg         eofWait_q;
    reg         brkWait_q;
    reg         brkIdle_q;
    reg         rxBusy_q;
    reg  [2:0]  bitCnt_q;
    reg  [19:0] domCnt_q;
    reg         invFlag_q;
    reg         crcFlag_q;
    reg         loa_q;
    reg  [5:0]  vector;
    reg         abortNow;

    wire ignore_message = ctrl1_q[`VBEDC_BIT_IGNORE_MESSAGE];
    wire ie   = ctrl1_q[`VBEDC_BIT_IE];

    // ----------------------------------------
    // Receive path and symbol decode
    // ----------------------------------------
    // Active (dominant) is high after the polarity fix
    assign rxData = delay_q[`VBEDC_BIT_RECEIVE_POLARITY] ? rxPin : ~rxPin;
    // Only the off-chip path exists; bit is passed out as written
    assign txSelect = delay_q[`VBEDC_BIT_ATE];

    wire sSof = symHit(symStb, symCode, `VBEDC_SYM_SOF);
    wire sEod = symHit(symStb, symCode, `VBEDC_SYM_EOD);
    wire sEof = symHit(symStb, symCode, `VBEDC_SYM_EOF);
    wire sBrk = symHit(symStb, symCode, `VBEDC_SYM_BRK);
    wire sInv = symHit(symStb, symCode, `VBEDC_SYM_INV);
    wire sD0  = symHit(symStb, symCode, `VBEDC_SYM_D0);
    wire sD1  = symHit(symStb, symCode, `VBEDC_SYM_D1);

    wire sending  = (tx_q == TX_SEND);
    wire offByte  = rxBusy_q & (bitCnt_q != 3'h0);
    // Own EOD overwritten by an active symbol
    wire eodClash = sending & eodPhase & rxData;
    wire framing  = ((sEod | sEof) & offByte) | eodClash;
    wire rxSymErr = sInv & rxBusy_q;
    // Noise counts from the start-of-frame drive onwards, not only mid-frame
    wire txNoise  = txDrive & sInv;
    wire crcEvt   = crcBad & rxBusy_q;

    // Dominant-length watch for a supply short
    wire shortHit = rxData & (domCnt_q == SHORT_CYC);
    wire loaHit   = rxData & (domCnt_q == LOA_CYC);
    wire gndFault = (tx_q == TX_SOF) & sofWindowEnd & ~rxData;

    // Any cause of the invalid-symbol condition
    wire invEvt = rxSymErr | framing | sBrk | txNoise | shortHit | gndFault;

    // ----------------------------------------
    // Dominant counter, saturating
    // ----------------------------------------
    always @(posedge clk)
    begin
        if (sys_rst)
            domCnt_q <= 20'h0_0000;
        else if (!rxData)
            domCnt_q <= 20'h0_0000;
        else if (domCnt_q != 20'hF_FFFF)
            domCnt_q <= domCnt_q + 20'h0_0001;
    end

    // ----------------------------------------
    // Frame tracking and recovery waits
    // ----------------------------------------
    // eofWait_q ORs its set terms after the clear so a same-cycle event wins; rxBusy_q lets its clear win
    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            eofWait_q <= 1'b0;
            brkWait_q <= 1'b0;
            brkIdle_q <= 1'b0;
            rxBusy_q  <= 1'b0;
            bitCnt_q  <= 3'h0;
        end
        else
        begin
            // Hold off until the frame end after these faults
            eofWait_q <= (eofWait_q & ~sEof) | framing | crcEvt
                       | shortHit | gndFault;
            // BREAK: bus must idle, then a fresh SOF is taken
            if (sBrk)
            begin
                brkWait_q <= 1'b1;
                brkIdle_q <= 1'b0;
            end
            else if (sSof & brkIdle_q)
            begin
                brkWait_q <= 1'b0;
                brkIdle_q <= 1'b0;
            end
            else if (brkWait_q & busIdle)
                brkIdle_q <= 1'b1;
            // Frame in progress; ignored frames are dropped here
            if (sBrk | sEof | framing | crcEvt | (ignore_message & ~sSof))
                rxBusy_q <= 1'b0;
            else if (sSof & (~brkWait_q | brkIdle_q))
                rxBusy_q <= 1'b1;
            if (sSof)
                bitCnt_q <= 3'h0;
            else if (sD0 | sD1)
                bitCnt_q <= bitCnt_q + 3'h1;
        end
    end

    // Receiver is deaf while any recovery wait is open
    assign rxSuspend = ignore_message | eofWait_q | brkWait_q;

    // ----------------------------------------
    // Transmit gate state machine
    // ----------------------------------------
    // No state drives a long dominant pulse, so a BREAK is never sent
    assign txDrive = (tx_q == TX_SOF) | sending;
    // Start only on a passive, idle bus with no recovery pending
    assign txStart = (tx_q == TX_DEFER) & busIdle & ~rxData
                   & ~eofWait_q & ~brkWait_q & ~sBrk;
    assign txAbort = abortNow;

    always @*
    begin
        tx_d = tx_q;
        abortNow = 1'b0;
        case (tx_q)
            TX_IDLE:
            begin
                if (reqPend_q | txReq)
                    tx_d = TX_DEFER;
            end
            TX_DEFER:
            begin
                if (txStart)
                    tx_d = TX_SOF;
            end
            TX_SOF:
            begin
                if (gndFault | sBrk | txNoise)
                begin
                    abortNow = 1'b1;
                    tx_d = TX_IDLE;
                end
                else if (sofWindowEnd)
                    tx_d = TX_SEND;
            end
            TX_SEND:
            begin
                if (txNoise | framing | sBrk)
                begin
                    abortNow = 1'b1;
                    tx_d = TX_IDLE;
                end
                else if (txDone)
                    tx_d = TX_IDLE;
            end
            default:
                tx_d = TX_IDLE;
        endcase
    end

    // An aborted frame drops its request: the CPU must ask again
    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            tx_q      <= TX_IDLE;
            reqPend_q <= 1'b0;
        end
        else
        begin
            tx_q <= tx_d;
            if (txReq)
                reqPend_q <= 1'b1;
            else if (txStart | abortNow)
                reqPend_q <= 1'b0;
        end
    end

    // ----------------------------------------
    // Status flags and state vector
    // ----------------------------------------
    wire svrRd = regRd & (regSel == `VBEDC_IDX_SVR);

    // Highest pending source wins; a read retires the invalid or CRC flag shown, buffer-empty follows txBufEmpty
    always @*
    begin
        if (invFlag_q)
            vector = `VBEDC_SV_INV;
        else if (crcFlag_q)
            vector = `VBEDC_SV_CRC;
        else if (txBufEmpty)
            vector = `VBEDC_SV_TXE;
        else
            vector = `VBEDC_SV_NONE;
    end

    // Ignore mode holds the sticky bits at reset
    always @(posedge clk)
    begin
        if (sys_rst | ignore_message)
        begin
            invFlag_q <= 1'b0;
            crcFlag_q <= 1'b0;
            loa_q     <= 1'b0;
        end
        else
        begin
            invFlag_q <= invEvt | (invFlag_q & ~svrRd);
            crcFlag_q <= crcEvt | (crcFlag_q & ~(svrRd & ~invFlag_q));
            loa_q     <= loaHit | (loa_q & ~svrRd);
        end
    end

    assign lostArb = loa_q;
    // Requests persist until retired; only code 0x20 survives ignore
    assign irq = ie & (vector != `VBEDC_SV_NONE);

    // ----------------------------------------
    // CPU registers
    // ----------------------------------------
    // Delay register takes one write per reset; the lock is not visible
    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            delay_q     <= `VBEDC_DELAY_RST;
            delayLock_q <= 1'b0;
        end
        else if (regWr & (regSel == `VBEDC_IDX_DELAY) & ~delayLock_q)
        begin
            delay_q     <= regWrData;
            delayLock_q <= 1'b1;
        end
    end

    // Software write beats the self-clear in the same cycle
    always @(posedge clk)
    begin
        if (sys_rst)
            ctrl1_q <= `VBEDC_CTRL1_RST;
        else if (regWr & (regSel == `VBEDC_IDX_CTRL1))
            ctrl1_q <= regWrData;
        else if (sSof | sBrk)
            ctrl1_q[`VBEDC_BIT_IGNORE_MESSAGE] <= 1'b0;
    end

    // Expected transceiver delay, registered for timing users
    always @(posedge clk)
    begin
        if (sys_rst)
            delayCyc <= dlyCyc(DELAY_RST[3:0]);
        else
            delayCyc <= dlyCyc(delay_q[3:0]);
    end

    // Read data lands one cycle after the read strobe
    always @(posedge clk)
    begin
        if (sys_rst)
            regRdData <= 8'h00;
        else if (regRd)
        begin
            case (regSel)
                `VBEDC_IDX_DELAY: regRdData <= delay_q;
                `VBEDC_IDX_CTRL1: regRdData <= ctrl1_q;
                `VBEDC_IDX_SVR:   regRdData <= {loa_q, 1'b0, vector};
                default:          regRdData <= 8'h00;
            endcase
        end
    end

endmodule

// ===== verification/vbedc_error_ctl_checker.sv
// Concurrent port checks for the VPW error and delay control block
module vbedc_error_ctl_checker #(
    parameter [19:0] SHORT_CYC = 20'h0_0014,
    parameter [19:0] LOA_CYC   = 20'h0_0028
)(
    input wire        clk,
    input wire        sys_rst,
    input wire [1:0]  regSel,
    input wire        regWr,
    input wire        regRd,
    input wire [7:0]  regWrData,
    input wire [7:0]  regRdData,
    input wire        rxPin,
    input wire        symStb,
    input wire [2:0]  symCode,
    input wire        busIdle,
    input wire        eodPhase,
    input wire        crcBad,
    input wire        txReq,
    input wire        txBufEmpty,
    input wire        sofWindowEnd,
    input wire        txDone,
    input wire        rxData,
    input wire        txStart,
    input wire        txDrive,
    input wire        txAbort,
    input wire        rxSuspend,
    input wire        irq,
    input wire [10:0] delayCyc,
    input wire        txSelect,
    input wire        lostArb
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // Single clock domain, so one clocking and one disable
    // ----------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    AST_DELAY: assert property (delayCyc >= 11'h1C2 && delayCyc <= 11'h4B0 && delayCyc % 11'h032 == 11'h000)
        else $error("Delay count outside the legal set");
    AST_DEFER: assert property (txStart |-> busIdle && !rxData)
        else $error("Transmit started on a busy or dominant bus");
    AST_START: assert property (txStart |=> txDrive)
        else $error("Start pulse not followed by start-of-frame drive");
    AST_SOF_FAIL: assert property (sofWindowEnd && txDrive && !rxData |-> txAbort ##1 (rxSuspend && !txDrive))
        else $error("Undriveable start-of-frame not aborted into end-of-frame wait");
    AST_ABORT: assert property (txAbort |=> !txDrive [*2])
        else $error("Drive continued after an abort");
    AST_NOISE: assert property (symStb && symCode == 3'h6 && txDrive |-> txAbort)
        else $error("Noise while sending did not abort at once");
    AST_BREAK: assert property (symStb && symCode == 3'h5 |=> rxSuspend && !txDrive)
        else $error("Break did not suspend the receiver");
    AST_RD_HOLD: assert property (!$past(regRd) |-> $stable(regRdData))
        else $error("Read data moved without a read");
endmodule

bind vbedc_error_ctl vbedc_error_ctl_checker #(.SHORT_CYC(SHORT_CYC), .LOA_CYC(LOA_CYC)) chk (.*);

// ===== verification/vbedc_xcvr_model.sv
// Behavioural off-chip transceiver with bus fault injection
module vbedc_xcvr_model (
    input  wire       txDrive,
    input  wire [1:0] fault,
    input  wire       invert,
    output wire       rxPin
);
    timeunit 1ns;
    timeprecision 1ps;
    wire busDom;

    // Battery short pins the bus dominant; a ground short swallows our drive
    assign busDom = (fault == 2'h1) | (txDrive & (fault != 2'h2));
    // Some transceivers hand back the bus level inverted
    assign rxPin = invert ? ~busDom : busDom;
endmodule

// ===== verification/vpw_bus_error_and_delay_control_tb_top.sv
// Self-checking bench for the VPW error and delay control block
`include "vbedc_map.vh"
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_total++; $display("Error t=%0t got=%h exp=%h", $time, a, b); end end
module vpw_bus_error_and_delay_control_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic [1:0]  regSel = 2'h0;
    logic        regWr = 1'b0;
    logic        regRd = 1'b0;
    logic [7:0]  regWrData = 8'h00;
    logic        symStb = 1'b0;
    logic [2:0]  symCode = 3'h0;
    logic        busIdle = 1'b1;
    logic [2:0]  pls = 3'h0;
    logic        txBufEmpty = 1'b0;
    logic [1:0]  fault = 2'h0;
    logic        invert = 1'b0;
    int          err_total = 0;
    int          tests_run = 0;
    wire         txReq = pls[2];
    wire         crcBad = pls[1];
    wire         sofWindowEnd = pls[0];
    logic        eodPhase = 1'b0;
    wire         txDone = 1'b0;
    wire [7:0]   regRdData;
    wire [10:0]  delayCyc;
    wire         rxPin, rxData, txStart, txDrive, txAbort, rxSuspend, irq, txSelect, lostArb;

    // Short fault counts keep the battery-short case to a few dozen cycles
    vbedc_error_ctl #(.SHORT_CYC(20'h0_0014), .LOA_CYC(20'h0_0028)) DUT (.*);
    vbedc_xcvr_model xcvr (.txDrive(txDrive), .fault(fault), .invert(invert), .rxPin(rxPin));

    initial
    forever #10 clk = ~clk;

    // ----------------------------------------
    // Access and stimulus tasks
    // ----------------------------------------
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic rst;
        @(posedge clk);
        sys_rst <= 1'b1;
        wt(8);
        sys_rst <= 1'b0;
    endtask
    task automatic wr(input [1:0] s, input [7:0] d);
        @(posedge clk);
        regWr <= 1'b1;
        regSel <= s;
        regWrData <= d;
        @(posedge clk);
        regWr <= 1'b0;
    endtask
    task automatic rd(input [1:0] s, input [7:0] e);
        @(posedge clk);
        regRd <= 1'b1;
        regSel <= s;
        @(posedge clk);
        regRd <= 1'b0;
        #1 `CHK(regRdData, e)
    endtask
    // One idle cycle between symbols so the strobe never toggles twice in a step
    task automatic sym(input [2:0] c);
        @(posedge clk);
        symStb <= 1'b1;
        symCode <= c;
        @(posedge clk);
        symStb <= 1'b0;
        #1;
    endtask
    task automatic pulse(input [2:0] p);
        @(posedge clk);
        pls <= p;
        @(posedge clk);
        pls <= 3'h0;
        #1;
    endtask
    task automatic waitDrv;
        int i;
        for (i = 0; i < 50 && txDrive !== 1'b1; i++)
            @(posedge clk) #1;
        `CHK(txDrive, 1'b1)
        if (txDrive !== 1'b1)
            end_of_test();
    endtask
    task automatic end_of_test;
        $display("Checks %0d, mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        rst();
        rd(`VBEDC_IDX_DELAY, 8'h47);
        `CHK(delayCyc, 11'h320)
        rd(`VBEDC_IDX_CTRL1, 8'h00);
        rd(2'h3, 8'h00);
        wr(`VBEDC_IDX_DELAY, 8'h40);
        wr(`VBEDC_IDX_DELAY, 8'hCF);
        wt(2);
        rd(`VBEDC_IDX_DELAY, 8'h40);
        `CHK(delayCyc, 11'h1C2)
        rst();
        wr(`VBEDC_IDX_DELAY, 8'h0F);
        invert <= 1'b1;
        wt(2);
        `CHK(delayCyc, 11'h4B0)
        `CHK(txSelect, 1'b0)
        `CHK(rxData, 1'b0)
        wr(`VBEDC_IDX_CTRL1, 8'h02);
        // Noise in mid-frame while sending
        pulse(3'h4);
        waitDrv();
        pulse(3'h1);
        sym(3'h6);
        `CHK(txDrive, 1'b0)
        rd(2'h2, 8'h1C);
        // Ground short: start-of-frame cannot go dominant
        fault <= 2'h2;
        sym(3'h4);
        pulse(3'h4);
        waitDrv();
        pulse(3'h1);
        `CHK(rxSuspend, 1'b1)
        rd(2'h2, 8'h1C);
        fault <= 2'h0;
        sym(3'h4);
        wt(10);
        `CHK(txDrive, 1'b0)
        // Framing error off a byte boundary
        sym(3'h2);
        repeat (3) sym(3'h1);
        sym(3'h3);
        `CHK(rxSuspend, 1'b1)
        rd(2'h2, 8'h1C);
        sym(3'h4);
        `CHK(rxSuspend, 1'b0)
        // CRC error ranks above buffer-empty
        sym(3'h2);
        repeat (8) sym(3'h0);
        txBufEmpty <= 1'b1;
        pulse(3'h2);
        `CHK(rxSuspend, 1'b1)
        rd(2'h2, 8'h18);
        rd(2'h2, 8'h20);
        txBufEmpty <= 1'b0;
        sym(3'h4);
        // Break: flagged, cleared by a read, then idle and a fresh start needed
        // Bus kept busy so the first start after the break must be refused
        busIdle <= 1'b0;
        sym(3'h5);
        rd(2'h2, 8'h1C);
        rd(2'h2, 8'h00);
        sym(3'h2);
        `CHK(rxSuspend, 1'b1)
        busIdle <= 1'b1;
        wt(2);
        sym(3'h2);
        `CHK(rxSuspend, 1'b0)
        sym(3'h4);
        // Ignore bit masks all but buffer-empty and clears on a start
        wr(`VBEDC_IDX_CTRL1, 8'h82);
        sym(3'h6);
        `CHK(irq, 1'b0)
        rd(2'h2, 8'h00);
        txBufEmpty <= 1'b1;
        wt(2);
        `CHK(irq, 1'b1)
        txBufEmpty <= 1'b0;
        sym(3'h2);
        rd(`VBEDC_IDX_CTRL1, 8'h02);
        sym(3'h4);
        // Interrupt enable gates a request that stays pending
        wr(`VBEDC_IDX_CTRL1, 8'h00);
        sym(3'h2);
        sym(3'h6);
        `CHK(irq, 1'b0)
        wr(`VBEDC_IDX_CTRL1, 8'h02);
        wt(1);
        `CHK(irq, 1'b1)
        rd(2'h2, 8'h1C);
        sym(3'h4);
        // Battery short before the end-of-data case, since the arbitration flag may outlive it
        fault <= 2'h1;
        pulse(3'h4);
        wt(60);
        `CHK(txDrive, 1'b0)
        `CHK(lostArb, 1'b1)
        rd(2'h2, 8'h9C);
        fault <= 2'h0;
        wt(5);
        `CHK(txDrive, 1'b0)
        sym(3'h4);
        pulse(3'h4);
        waitDrv();
        // Active symbol seen during own end-of-data is a framing error
        pulse(3'h1);
        eodPhase <= 1'b1;
        wt(1);
        #1;
        eodPhase <= 1'b0;
        `CHK(txDrive, 1'b0)
        rd(2'h2, 8'h1C);
        end_of_test();
    end
endmodule
